// *** logic/agpsd_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "agpsd_map.svh"

module agpsd_decoder
   import agpsd_pkg::*;
#(
   parameter int SHADOW_REGIONS = 16
) (
   input  wire logic                      clock_i,
   input  wire logic                      srst_i,

   // configuration
   input  wire logic [11:0]               mem_window_base_i,
   input  wire logic [11:0]               mem_window_limit_i,
   input  wire logic [11:0]               prefetch_window_base_i,
   input  wire logic [11:0]               prefetch_window_limit_i,
   input  wire logic                      mem_access_enable_i,
   input  wire logic                      compatible_smm_space_en_i,
   input  wire logic                      high_smm_segment_en_i,
   input  wire logic                      top_memory_smm_segment_en_i,
   input  wire logic [1:0]                top_segment_size_i,
   input  wire logic                      smm_data_open_i,
   input  wire logic [31:0]               top_of_main_memory_i,
   input  wire logic [SHADOW_REGIONS-1:0] shadow_read_dram_i,
   input  wire logic [SHADOW_REGIONS-1:0] shadow_write_dram_i,
   input  wire logic                      flag_clear_i,

   // request
   input  wire logic                      req_valid_i,
   input  wire agpsd_src_e                req_src_i,
   input  wire logic [31:0]               req_addr_i,
   input  wire logic                      req_write_i,
   input  wire logic [7:0]                req_be_i,
   input  wire logic                      req_translated_i,
   input  wire logic                      req_smm_attr_i,
   input  wire logic                      req_writeback_i,

   // decoded answer
   output logic                           resp_valid_o,
   output agpsd_tgt_e                     resp_target_o,
   output logic [31:0]                    resp_addr_o,
   output logic [7:0]                     resp_be_o,
   output logic                           resp_snoop_o,
   output logic                           invalid_translation_entry_flag_o
);

   function automatic logic in_range(input logic [31:0] a,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // window bounds widened to byte addresses
   function automatic logic [31:0] win_lo(input logic [11:0] f);
      win_lo = {f, `AGPSD_WIN_BASE_LOW};
   endfunction

   function automatic logic [31:0] win_hi(input logic [11:0] f);
      win_hi = {f, `AGPSD_WIN_LIM_LOW};
   endfunction

   logic [31:0] a;
   assign a = req_addr_i;

   // graphics port windows
   wire mem_win_hit = mem_access_enable_i
      && (mem_window_limit_i >= mem_window_base_i)
      && in_range(a, win_lo(mem_window_base_i),
                  win_hi(mem_window_limit_i));
   wire pf_win_hit = mem_access_enable_i
      && (prefetch_window_limit_i >= prefetch_window_base_i)
      && in_range(a, win_lo(prefetch_window_base_i),
                  win_hi(prefetch_window_limit_i));
   wire window_hit = mem_win_hit || pf_win_hit;

   // top segment bounds
   logic [31:0] top_memory_smm_segment_size;
   always_comb begin
      case (top_segment_size_i)
         `AGPSD_SZ_128K: top_memory_smm_segment_size = `AGPSD_TOP_MEMORY_SMM_SEGMENT_128K;
         `AGPSD_SZ_256K: top_memory_smm_segment_size = `AGPSD_TOP_MEMORY_SMM_SEGMENT_256K;
         `AGPSD_SZ_512K: top_memory_smm_segment_size = `AGPSD_TOP_MEMORY_SMM_SEGMENT_512K;
         default:        top_memory_smm_segment_size = `AGPSD_TOP_MEMORY_SMM_SEGMENT_1M;
      endcase
   end
   wire [31:0] top_memory_smm_segment_lo = top_of_main_memory_i - top_memory_smm_segment_size;
   // top of memory is exclusive: last byte is one below it
   wire top_memory_smm_segment_hit = top_memory_smm_segment_en_i
      && (a >= top_memory_smm_segment_lo) && (a < top_of_main_memory_i);

   // smm transaction address ranges
   wire compat_range = in_range(a, `AGPSD_COMPAT_LO, `AGPSD_COMPAT_HI);
   wire high_range = in_range(a, `AGPSD_HIGH_LO, `AGPSD_HIGH_HI);
   wire compat_hit = compatible_smm_space_en_i && compat_range;
   wire high_hit = high_smm_segment_en_i && high_range;

   // dram holding smm code: compatible range backs both c and h
   wire smm_dram_hit = top_memory_smm_segment_hit || (compat_range
      && (compatible_smm_space_en_i || high_smm_segment_en_i));
   wire smm_addr_hit = compat_hit || high_hit || top_memory_smm_segment_hit;

   wire enough_mem = top_of_main_memory_i >= `AGPSD_MEM_256M;
   wire from_cpu = (req_src_i == AGPSD_SRC_CPU);
   wire from_hub = (req_src_i == AGPSD_SRC_HUB);
   // open-for-data lets plain cycles see compatible smm;
   // open and close together are left to software to avoid
   wire cpu_smm_ok = req_smm_attr_i || smm_data_open_i;

   // shadow regions in c0000-fffff
   wire shadow_area = in_range(a, `AGPSD_SHADOW_LO, `AGPSD_SHADOW_HI);
   logic [SHADOW_REGIONS-1:0] shadow_sel;
   genvar g;
   generate
      for (g = 0; g < SHADOW_REGIONS; g++) begin : g_shadow
         assign shadow_sel[g] = shadow_area
            && (a[`AGPSD_SHADOW_MSB:`AGPSD_SHADOW_LSB] == 4'(g));
      end
   endgenerate
   wire shadow_dram = req_write_i
      ? |(shadow_sel & shadow_write_dram_i)
      : |(shadow_sel & shadow_read_dram_i);

   // decode result
   agpsd_tgt_e  tgt_next;
   logic [31:0] addr_next;
   logic [7:0]  be_next;
   logic        snoop_next;
   logic        bad_xlat;

   // dram ends one byte below the programmed top of memory
   function automatic logic below_top(input logic [31:0] x,
                                      input logic [31:0] top);
      below_top = (x < top);
   endfunction

   wire in_dram = below_top(a, top_of_main_memory_i);

   // translated smm hit: redirected to zero, writes lose byte enables
   wire xlat_smm = req_translated_i && smm_dram_hit
      && !(high_range && high_smm_segment_en_i);
   wire [7:0] zero_be = req_write_i ? `AGPSD_BE_OFF : req_be_i;

   // smm rights for the cpu top and high segments
   wire cpu_seg_ok = req_smm_attr_i || req_writeback_i;

   // priority order matters: translated checks come before the
   // per-master rules so a translated hit can never slip past
   always_comb begin
      tgt_next   = AGPSD_TGT_HUB;
      addr_next  = a;
      be_next    = req_be_i;
      snoop_next = from_hub;
      bad_xlat   = 1'b0;

      if (req_translated_i && high_hit) begin
         // high transaction range is not smm dram: pass through
         if (enough_mem) begin
            tgt_next = AGPSD_TGT_DRAM;
         end else begin
            tgt_next = AGPSD_TGT_HUB;
         end

      end else if (xlat_smm) begin
         // data is dropped, not faulted: the flag tells software
         tgt_next  = AGPSD_TGT_DRAM;
         addr_next = `AGPSD_ADDR_ZERO;
         be_next   = zero_be;
         bad_xlat  = 1'b1;

      end else if (!from_cpu && smm_addr_hit) begin
         // direct access by a bus master is treated as invalid
         tgt_next  = AGPSD_TGT_DRAM;
         addr_next = `AGPSD_ADDR_ZERO;
         be_next   = zero_be;

      end else if (!from_cpu) begin
         // graphics windows are not decoded for bus masters
         if (in_dram) begin
            tgt_next = AGPSD_TGT_DRAM;
         end else begin
            tgt_next = AGPSD_TGT_HUB;
         end

      end else if (high_hit) begin
         if (cpu_seg_ok) begin
            tgt_next  = AGPSD_TGT_DRAM;
            addr_next = a - `AGPSD_HIGH_OFFSET;
         end else begin
            tgt_next = AGPSD_TGT_TERMINATE;
         end

      end else if (top_memory_smm_segment_hit) begin
         // writebacks must land to keep caches coherent
         if (cpu_seg_ok) begin
            tgt_next = AGPSD_TGT_DRAM;
         end else begin
            tgt_next = AGPSD_TGT_TERMINATE;
         end

      end else if (compat_hit) begin
         // without smm rights the legacy video range stays on the hub
         if (cpu_smm_ok) begin
            tgt_next = AGPSD_TGT_DRAM;
         end else begin
            tgt_next = AGPSD_TGT_HUB;
         end

      end else if (window_hit) begin
         tgt_next = AGPSD_TGT_GPORT;

      end else if (shadow_area) begin
         // reads and writes may go to different places while copying
         if (shadow_dram) begin
            tgt_next = AGPSD_TGT_DRAM;
         end else begin
            tgt_next = AGPSD_TGT_HUB;
         end

      end else if (in_dram) begin
         tgt_next = AGPSD_TGT_DRAM;

      end else begin
         tgt_next = AGPSD_TGT_HUB;
      end
   end

   // registered answer, one cycle after the request
   logic flag_reg;
   wire  flag_set = req_valid_i && bad_xlat;
   // a hit in the clearing cycle keeps the flag set
   wire  flag_next = flag_set || (flag_reg && !flag_clear_i);

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         resp_valid_o  <= 1'b0;
         resp_target_o <= AGPSD_TGT_HUB;
         resp_addr_o   <= `AGPSD_ADDR_ZERO;
         resp_be_o     <= `AGPSD_BE_OFF;
         resp_snoop_o  <= 1'b0;
         flag_reg      <= 1'b0;
      end else begin
         resp_valid_o  <= req_valid_i;
         resp_target_o <= tgt_next;
         resp_addr_o   <= addr_next;
         resp_be_o     <= be_next;
         resp_snoop_o  <= req_valid_i && snoop_next;
         flag_reg      <= flag_next;
      end
   end

   assign invalid_translation_entry_flag_o = flag_reg;

endmodule

`default_nettype wire

// *** logic/agpsd_map.svh ***
`ifndef AGPSD_MAP_SVH
`define AGPSD_MAP_SVH

// compatible smm space, also the dram behind the high segment
`define AGPSD_COMPAT_LO    32'h000A_0000
`define AGPSD_COMPAT_HI    32'h000B_FFFF
// high smm segment transaction range
`define AGPSD_HIGH_LO      32'hFEDA_0000
`define AGPSD_HIGH_HI      32'hFEDB_FFFF
// high address minus this lands on the compatible dram range
`define AGPSD_HIGH_OFFSET  32'hFED0_0000
// legacy range that translated addresses must never target
`define AGPSD_LEGACY_HI    32'h000F_FFFF
// shadowable rom area, split into 16 kB regions
`define AGPSD_SHADOW_LO    32'h000C_0000
`define AGPSD_SHADOW_HI    32'h000F_FFFF
`define AGPSD_SHADOW_LSB   14
`define AGPSD_SHADOW_MSB   17
// window base/limit fields cover address bits 31:20
`define AGPSD_WIN_LSB      20
`define AGPSD_WIN_BASE_LOW 20'h0_0000
`define AGPSD_WIN_LIM_LOW  20'hF_FFFF
// top segment sizes by select code
`define AGPSD_TOP_MEMORY_SMM_SEGMENT_128K    32'h0002_0000
`define AGPSD_TOP_MEMORY_SMM_SEGMENT_256K    32'h0004_0000
`define AGPSD_TOP_MEMORY_SMM_SEGMENT_512K    32'h0008_0000
`define AGPSD_TOP_MEMORY_SMM_SEGMENT_1M      32'h0010_0000
`define AGPSD_SZ_128K      2'h0
`define AGPSD_SZ_256K      2'h1
`define AGPSD_SZ_512K      2'h2
// least memory for unremapped high-range translated access
`define AGPSD_MEM_256M     32'h1000_0000
`define AGPSD_ADDR_ZERO    32'h0000_0000
`define AGPSD_BE_OFF       8'h00

`endif

// *** logic/agpsd_pkg.sv ***
package agpsd_pkg;

   // originator of a memory cycle
   typedef enum logic [1:0] {
      AGPSD_SRC_CPU,
      AGPSD_SRC_GP_PIPE,
      AGPSD_SRC_GP_FRAME,
      AGPSD_SRC_HUB
   } agpsd_src_e;

   // where the decoded cycle goes
   typedef enum logic [1:0] {
      AGPSD_TGT_DRAM,
      AGPSD_TGT_GPORT,
      AGPSD_TGT_HUB,
      AGPSD_TGT_TERMINATE
   } agpsd_tgt_e;

endpackage

// *** verif/agpsd_decoder_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "agpsd_map.svh"
module agpsd_decoder_assertions
   import agpsd_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        srst_i,
   input wire logic        mem_access_enable_i,
   input wire logic        high_smm_segment_en_i,
   input wire logic        flag_clear_i,
   input wire logic        req_valid_i,
   input wire agpsd_src_e  req_src_i,
   input wire logic [31:0] req_addr_i,
   input wire logic        req_write_i,
   input wire logic        req_translated_i,
   input wire logic        req_smm_attr_i,
   input wire logic        req_writeback_i,
   input wire logic        resp_valid_o,
   input wire agpsd_tgt_e  resp_target_o,
   input wire logic [31:0] resp_addr_o,
   input wire logic [7:0]  resp_be_o,
   input wire logic        resp_snoop_o,
   input wire logic        invalid_translation_entry_flag_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   wire logic flag = invalid_translation_entry_flag_o;
   wire logic high_hit = req_valid_i && req_src_i == AGPSD_SRC_CPU
      && !req_translated_i && high_smm_segment_en_i && req_smm_attr_i
      && req_addr_i >= `AGPSD_HIGH_LO && req_addr_i <= `AGPSD_HIGH_HI;
   chk_resp_pulse:
      assert property (req_valid_i |=> resp_valid_o)
      else $error("response missing");
   chk_resp_quiet:
      assert property (!req_valid_i |=> !resp_valid_o)
      else $error("response without request");
   chk_hub_snoop:
      assert property (req_valid_i |=> resp_snoop_o
         == ($past(req_src_i) == AGPSD_SRC_HUB)) else $error("bad snoop");
   chk_flag_sticky:
      assert property (flag && !flag_clear_i |=> flag)
      else $error("flag dropped");
   chk_flag_zero:
      assert property ($rose(flag) |-> resp_valid_o && $past(req_translated_i)
         && resp_target_o == AGPSD_TGT_DRAM && resp_addr_o == 32'h0000_0000)
      else $error("flagged hit not sent to zero");
   chk_flag_be:
      assert property ($rose(flag) && $past(req_write_i) |-> resp_be_o == 8'h00)
      else $error("flagged write kept enables");
   chk_high_remap:
      assert property (high_hit |=> resp_target_o == AGPSD_TGT_DRAM
         && resp_addr_o == $past(req_addr_i) - `AGPSD_HIGH_OFFSET)
      else $error("high segment not remapped");
   chk_term_cause:
      assert property (resp_valid_o && resp_target_o == AGPSD_TGT_TERMINATE
         |-> $past(req_src_i) == AGPSD_SRC_CPU && !$past(req_smm_attr_i)
         && !$past(req_writeback_i)) else $error("bad terminate");
   chk_gport_enable:
      assert property (resp_valid_o && resp_target_o == AGPSD_TGT_GPORT
         |-> $past(req_src_i) == AGPSD_SRC_CPU && $past(mem_access_enable_i))
      else $error("graphics port claim while disabled");
endmodule
bind agpsd_decoder agpsd_decoder_assertions chk (.*);
`default_nettype wire

// *** verif/agpsd_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "agpsd_map.svh"
module agpsd_master_model
   import agpsd_pkg::*;
(
   input  wire logic clock_i,
   output logic        req_valid_o,
   output agpsd_src_e  req_src_o,
   output logic [31:0] req_addr_o,
   output logic [3:0]  req_flags_o,
   output logic [7:0]  req_be_o
);
   initial begin
      req_valid_o = 1'b0;
      req_src_o = AGPSD_SRC_CPU;
      req_addr_o = 32'h0000_0000;
      req_flags_o = 4'h0;
      req_be_o = 8'hFF;
   end
   // flags are write, translated, smm attribute, writeback
   task automatic send(input logic [1:0] s, input logic [31:0] a,
                       input logic [3:0] f, input logic hold);
      @(negedge clock_i);
      req_src_o = agpsd_src_e'(s);
      req_addr_o = a;
      req_flags_o = f;
      // translations never point at legacy dram
      if (a >= `AGPSD_COMPAT_LO && a <= `AGPSD_LEGACY_HI) req_flags_o[2] = 1'b0;
      req_valid_o = 1'b1;
      if (!hold) begin
         @(negedge clock_i);
         req_valid_o = 1'b0;
         // idle address must not look like the last request
         req_addr_o = ~a;
      end
   endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import agpsd_pkg::*;
   logic        clock_i = 1'b0, srst_i = 1'b1, mem_access_enable_i = 1'b1;
   logic        smm_data_open_i = 1'b0, flag_clear_i = 1'b0;
   logic        top_memory_smm_segment_en_i = 1'b1;
   logic [11:0] prefetch_window_limit_i = 12'hA3F;
   logic [1:0]  top_segment_size_i = 2'h0;
   logic [31:0] top_of_main_memory_i = 32'h1000_0000, lfsr = 32'hc7b8_5bc0;
   logic [15:0] shadow_read_dram_i = 16'h0000, shadow_write_dram_i = 16'h0000;
   logic [31:0] req_addr_i, resp_addr_o, ra;
   logic [3:0]  fl;
   logic [7:0]  req_be_i, resp_be_o;
   logic        req_valid_i, resp_valid_o, resp_snoop_o;
   logic        invalid_translation_entry_flag_o;
   agpsd_src_e  req_src_i;
   agpsd_tgt_e  resp_target_o;
   int          fail_count = 0, checks = 0, cyc = 0;
   wire logic [11:0] mem_window_base_i = 12'h800, mem_window_limit_i = 12'h80F;
   wire logic [11:0] prefetch_window_base_i = 12'hA00;
   wire logic compatible_smm_space_en_i = 1'b1, high_smm_segment_en_i = 1'b1;
   wire logic req_write_i = fl[3], req_translated_i = fl[2];
   wire logic req_smm_attr_i = fl[1], req_writeback_i = fl[0];
   initial forever #5 clock_i = ~clock_i;
   agpsd_master_model master (.clock_i(clock_i), .req_valid_o(req_valid_i),
      .req_src_o(req_src_i), .req_addr_o(req_addr_i), .req_flags_o(fl),
      .req_be_o(req_be_i));
   agpsd_decoder #(.SHADOW_REGIONS(16)) dut (.*);
   task automatic close_out();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // src 0 cpu 1 pipe 2 frame 3 hub; target 0 dram 1 gport 2 hub 3 term
   task automatic go(input logic [1:0] s, input logic [31:0] a,
                     input logic [3:0] f, input logic [1:0] t);
      master.send(s, a, f, 1'b0);
      chk("valid", resp_valid_o, 32'h0000_0001);
      chk("target", resp_target_o, t);
   endtask
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [1:0] route(input logic [31:0] a, input logic w);
      if (a[31:18] == 14'h0003) return (w ? shadow_write_dram_i[a[17:14]]
         : shadow_read_dram_i[a[17:14]]) ? 2'h0 : 2'h2;
      if (mem_access_enable_i && (a[31:20] inside {[12'h800:12'h80F]}
         || a[31:20] inside {[12'hA00:prefetch_window_limit_i]})) return 2'h1;
      return (a < top_of_main_memory_i) ? 2'h0 : 2'h2;
   endfunction
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      repeat (5) @(posedge clock_i);
      @(negedge clock_i) srst_i = 1'b0;
      foreach (lfsr[i]) begin
         ra = {lfsr[0] ? 8'h80 : 8'hA3, lfsr[27:4]} ^ {7'h00, lfsr[3], 24'h0};
         go(2'h0, ra, 4'h0, route(ra, 1'b0));
         lfsr = lfsr_next(lfsr);
         {shadow_read_dram_i, shadow_write_dram_i} = lfsr;
         ra = {14'h0003, lfsr[17:0]};
         go(2'h0, ra, {lfsr[6], 3'h0}, route(ra, lfsr[6]));
      end
      go(2'h0, 32'h80FF_FFFF, 4'h0, 2'h1);
      go(2'h0, 32'hA400_0000, 4'h0, 2'h2);
      mem_access_enable_i = 1'b0;
      go(2'h0, 32'h8000_0000, 4'h0, 2'h2);
      mem_access_enable_i = 1'b1;
      prefetch_window_limit_i = 12'h9FF;
      go(2'h0, 32'hA000_0000, 4'h0, 2'h2);
      go(2'h0, 32'hFEDA_1234, 4'h2, 2'h0);
      chk("addr", resp_addr_o, 32'h000A_1234);
      go(2'h0, 32'hFEDA_1234, 4'h0, 2'h3);
      go(2'h0, 32'h0FFE_0000, 4'h1, 2'h0);
      top_segment_size_i = 2'h3;
      go(2'h0, 32'h0FF0_0000, 4'h0, 2'h3);
      go(2'h0, 32'h0FFF_FFFC, 4'h2, 2'h0);
      chk("addr", resp_addr_o, 32'h0FFF_FFFC);
      go(2'h0, 32'h000B_0000, 4'h0, 2'h2);
      smm_data_open_i = 1'b1;
      go(2'h0, 32'h000B_0000, 4'h0, 2'h0);
      go(2'h1, 32'h0FFF_FFF0, 4'hC, 2'h0);
      chk("be", resp_be_o, 32'h0000_0000);
      chk("flag", invalid_translation_entry_flag_o, 32'h0000_0001);
      flag_clear_i = 1'b1;
      go(2'h2, 32'h0FFE_0200, 4'hC, 2'h0);
      flag_clear_i = 1'b0;
      chk("be", resp_be_o, 32'h0000_0000);
      go(2'h3, 32'h0FFE_0300, 4'h4, 2'h0);
      chk("snoop", resp_snoop_o, 32'h0000_0001);
      go(2'h1, 32'hFEDB_0000, 4'h4, 2'h0);
      chk("addr", resp_addr_o, 32'hFEDB_0000);
      top_of_main_memory_i = 32'h0800_0000;
      top_memory_smm_segment_en_i = 1'b0;
      go(2'h1, 32'hFEDB_0000, 4'h4, 2'h2);
      go(2'h3, 32'hFEDA_0000, 4'h8, 2'h0);
      chk("addr", resp_addr_o, 32'h0000_0000);
      repeat (8) master.send(2'h0, 32'h8000_0000, 4'h0, 1'b1);
      go(2'h0, 32'h0FF0_0000, 4'h0, 2'h2);
      close_out();
   end
endmodule
`default_nettype wire
